/* gdw_defs.svh */
// Purpose: constants for the gpio driven board watchdog
// Assumes: 100 MHz system clock
// Notes: offsets are byte offsets from the gpio io base
`ifndef GDW_DEFS_SVH
`define GDW_DEFS_SVH
`define GDW_LVL2_OFS 16'h0038
`define GDW_LVL3_OFS 16'h0048
`define GDW_BASE_CFG_OFS 8'h48
`define GDW_EN_N_BIT 0
`define GDW_SEL_LO_BIT 1
`define GDW_SEL_HI_BIT 3
`define GDW_SERVICE_BIT 23
`define GDW_LVL2_RESET 32'h0000_0001
`define GDW_LVL3_RESET 32'h0000_0000
`define GDW_CLK_NS 10
`define GDW_TICK_US 1000
`define GDW_TICK_CYC ((`GDW_TICK_US * 1000) / `GDW_CLK_NS)
`define GDW_T100MS_MS 100
`define GDW_T1S_MS 1000
`define GDW_T10S_MS 10000
`define GDW_T1MIN_MS 60000
`endif

/* gdw_pkg.sv */
// Purpose: types for the gpio driven board watchdog
// Assumes: nothing
// Notes: io request carried as one struct
package gdw_pkg;
    typedef struct packed
    {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } gdw_io_req_s;
    typedef enum logic [2:0]
    {
        GDW_OFF = 3'b001,
        GDW_RUN = 3'b010,
        GDW_FIRE = 3'b100
    } gdw_state_e;
endpackage : gdw_pkg

/* gdw_tick_gen.sv */
// Purpose: free-running tick divider
// Assumes: single clock domain
// Notes: tick is a one-cycle pulse every DIV cycles
`timescale 1ns/10ps
module gdw_tick_gen #(
    parameter int DIV = 100000
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    output logic o_tick
);
    // cycle counter, wraps at DIV-1
    logic [31:0] count;
    wire last = (count == 32'(DIV - 1));
    // divider runs without pause so every period shares one time base
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            count <= 32'h0000_0000;
            o_tick <= 1'b0;
        end
        else
        begin
            count <= last ? 32'h0000_0000 : count + 32'h0000_0001;
            o_tick <= last;
        end
    end
endmodule : gdw_tick_gen

/* gdw_watchdog.sv */
// Purpose: board watchdog steered by gpio level registers in io space
// Assumes: io requests are single-cycle strobes on the system clock
// Notes: the io base is supplied by the bridge config value on a port
// How it works
// - four periods: 100ms, 1s, 10s, 1min
// - enabled and expired raises system reset
// - enable is bit 0, active low
// - enable bit resets to one, disabled
// - 32-bit level register at base plus 38h
// - io base from bridge config 48-4Bh
// - low select is bit 1
// - indicator zero shows inverted low select, held low here until i_post_done is high
// - select input is complement of bit
// - select pair encodes period, ignored when off
// - high select is bit 3
// - service is bit 23 at base plus 48h
`timescale 1ns/10ps
`include "gdw_defs.svh"
module gdw_watchdog #(
    parameter int TICK_CYC = `GDW_TICK_CYC,
    parameter int T100MS_TICKS = `GDW_T100MS_MS,
    parameter int T1S_TICKS = `GDW_T1S_MS,
    parameter int T10S_TICKS = `GDW_T10S_MS,
    parameter int T1MIN_TICKS = `GDW_T1MIN_MS
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire gdw_pkg::gdw_io_req_s i_io_req,
    input wire logic [31:0] i_gpio_base_cfg,
    input wire logic i_post_done,
    output logic [31:0] o_io_rdata,
    output logic o_io_hit,
    output logic o_sys_reset,
    output logic o_diag_indicator_zero,
    output logic o_wdog_running
);
    import gdw_pkg::*;

    // level registers as seen by software
    logic [31:0] gpio_output_level_bank2;
    logic [31:0] gpio_output_level_bank3;
    // watchdog state and tick count
    gdw_state_e state;
    gdw_state_e next_state;
    logic [15:0] count;
    logic [15:0] next_count;
    logic service_prev;
    logic tick;

    // base from config
    // bit 0 is the io space indicator, low bits of the word are the base
    wire [15:0] io_base = {i_gpio_base_cfg[15:2], 2'b00};
    wire hit_lvl2 = (i_io_req.addr == io_base + `GDW_LVL2_OFS);
    wire hit_lvl3 = (i_io_req.addr == io_base + `GDW_LVL3_OFS);
    wire wr_lvl2 = i_io_req.wr && hit_lvl2;
    wire wr_lvl3 = i_io_req.wr && hit_lvl3;

    wire wdog_enable_n = gpio_output_level_bank2[`GDW_EN_N_BIT];
    wire wdog_period_sel_lo = gpio_output_level_bank2[`GDW_SEL_LO_BIT];
    wire wdog_period_sel_hi = gpio_output_level_bank2[`GDW_SEL_HI_BIT];
    wire wdog_service_toggle = gpio_output_level_bank3[`GDW_SERVICE_BIT];
    // inverted at the watchdog select inputs
    wire [1:0] sel_internal = ~{wdog_period_sel_hi, wdog_period_sel_lo};

    // pair 11 fastest, 00 slowest, by register bit value
    wire [15:0] limit =
        (sel_internal == 2'b00) ? 16'(T100MS_TICKS) :
        (sel_internal == 2'b01) ? 16'(T1S_TICKS) :
        (sel_internal == 2'b10) ? 16'(T10S_TICKS) :
        16'(T1MIN_TICKS);

    wire service_edge = (wdog_service_toggle != service_prev);
    wire expired = tick && (count + 16'h0001 >= limit);

    gdw_tick_gen #(
        .DIV(TICK_CYC)
    ) u_tick (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .o_tick(tick)
    );

    // register writes; bytes written as a whole word
    // disabled after reset
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            gpio_output_level_bank2 <= `GDW_LVL2_RESET;
            gpio_output_level_bank3 <= `GDW_LVL3_RESET;
        end
        else
        begin
            if (wr_lvl2)
            begin
                gpio_output_level_bank2 <= i_io_req.wdata;
            end
            if (wr_lvl3)
            begin
                gpio_output_level_bank3 <= i_io_req.wdata;
            end
        end
    end

    // read data is registered; unmapped reads return zero
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_io_rdata <= 32'h0000_0000;
            o_io_hit <= 1'b0;
        end
        else
        begin
            o_io_hit <= (i_io_req.rd || i_io_req.wr) && (hit_lvl2 || hit_lvl3);
            if (i_io_req.rd && hit_lvl2)
            begin
                o_io_rdata <= gpio_output_level_bank2;
            end
            else if (i_io_req.rd && hit_lvl3)
            begin
                o_io_rdata <= gpio_output_level_bank3;
            end
            else if (i_io_req.rd)
            begin
                o_io_rdata <= 32'h0000_0000;
            end
        end
    end

    // state machine: off, counting, reset raised
    always_comb
    begin
        next_state = state;
        next_count = count;
        case (state)
            GDW_OFF:
            begin
                next_count = 16'h0000;
                if (!wdog_enable_n)
                begin
                    next_state = GDW_RUN;
                end
            end
            GDW_RUN:
            begin
                if (wdog_enable_n)
                begin
                    next_state = GDW_OFF;
                    next_count = 16'h0000;
                end
                else if (service_edge)
                begin
                    next_count = 16'h0000;
                end
                else if (expired)
                begin
                    next_state = GDW_FIRE;
                end
                else if (tick)
                begin
                    next_count = count + 16'h0001;
                end
            end
            GDW_FIRE:
            begin
                // held until the system reset returns through i_rst_n
                next_state = GDW_FIRE;
            end
            default:
            begin
                next_state = GDW_OFF;
            end
        endcase
    end

    // state registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= GDW_OFF;
            count <= 16'h0000;
            service_prev <= 1'b0;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            service_prev <= wdog_service_toggle;
        end
    end

    // outputs from flip-flops
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_sys_reset <= 1'b0;
            o_diag_indicator_zero <= 1'b0;
            o_wdog_running <= 1'b0;
        end
        else
        begin
            o_sys_reset <= (next_state == GDW_FIRE);
            // led on when low select is zero and i_post_done is high
            o_diag_indicator_zero <= i_post_done && !wdog_period_sel_lo;
            o_wdog_running <= (next_state == GDW_RUN);
        end
    end
endmodule : gdw_watchdog

/* gdw_host_model.sv */
// Purpose: host software model issuing io accesses
// Assumes: single-cycle strobes, answer one cycle later
// Notes: released address and data lines show inverted values
`timescale 1ns/10ps
module gdw_host_model (
    input wire logic i_sys_clk,
    input wire logic [31:0] i_io_rdata,
    input wire logic i_io_hit,
    output gdw_pkg::gdw_io_req_s o_io_req
);
    import gdw_pkg::*;
    // bus idle before the first access
    initial o_io_req = '0;
    // one read or write access to any address
    // strobe for one cycle, take the answer at the next falling edge
    task io(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q, output logic h);
        @(negedge i_sys_clk);
        o_io_req = '{w, ~w, a, d};
        @(negedge i_sys_clk);
        q = i_io_rdata;
        h = i_io_hit;
        o_io_req = '{1'b0, 1'b0, ~a, ~d};
    endtask : io
endmodule : gdw_host_model

/* gdw_watchdog_sva.sv */
// Purpose: port checks of the board watchdog
// Assumes: one clock domain
// Notes: sees top ports only
`timescale 1ns/10ps
module gdw_watchdog_sva (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire gdw_pkg::gdw_io_req_s i_io_req,
    input wire logic [31:0] i_gpio_base_cfg,
    input wire logic i_post_done,
    input wire logic [31:0] o_io_rdata,
    input wire logic o_io_hit,
    input wire logic o_sys_reset,
    input wire logic o_diag_indicator_zero,
    input wire logic o_wdog_running
);
    import gdw_pkg::*;
    // base ignores the two low cfg bits
    wire logic [15:0] base = {i_gpio_base_cfg[15:2], 2'b00};
    wire logic hit2 = i_io_req.addr == base + 16'h0038;
    wire logic hit3 = i_io_req.addr == base + 16'h0048;
    wire logic en_wr = i_io_req.wr & hit2 & ~i_io_req.wdata[0];
    wire logic dis_wr = i_io_req.wr & hit2 & i_io_req.wdata[0];
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    a_hit_mapped: assert property ((i_io_req.wr || i_io_req.rd) && (hit2 || hit3) |=> o_io_hit)
        else $error("mapped access without hit");
    a_unmapped_zero: assert property (i_io_req.rd && !hit2 && !hit3 |=> !o_io_hit && o_io_rdata == 32'h0)
        else $error("unmapped read answered");
    a_rdata_hold: assert property (!i_io_req.rd |=> $stable(o_io_rdata))
        else $error("read data moved");
    a_reset_sticks: assert property (o_sys_reset |=> o_sys_reset)
        else $error("system reset dropped");
    a_fire_cause: assert property ($rose(o_sys_reset) |-> $past(o_wdog_running))
        else $error("reset raised while stopped");
    a_ind_gated: assert property (!i_post_done |=> !o_diag_indicator_zero)
        else $error("indicator lit before post");
    a_en_runs: assert property (en_wr && !o_sys_reset |-> ##[1:2] o_wdog_running)
        else $error("enable did not start");
    a_dis_stops: assert property (dis_wr && !o_sys_reset |-> ##2 !o_wdog_running)
        else $error("disable did not stop");
endmodule : gdw_watchdog_sva
bind gdw_watchdog gdw_watchdog_sva gdw_watchdog_sva_inst (.i_sys_clk, .i_rst_n, .i_io_req, .i_gpio_base_cfg,
    .i_post_done, .o_io_rdata, .o_io_hit, .o_sys_reset, .o_diag_indicator_zero, .o_wdog_running);

/* tb_gdw_watchdog.sv */
// Purpose: self-checking bench of the board watchdog
// Assumes: tick of 4 cycles, periods of 2 to 5 ticks
// Notes: timeouts allow one tick of phase either way
`timescale 1ns/10ps
module tb_gdw_watchdog;
    import gdw_pkg::*;
    localparam logic [15:0] L2 = 16'h0538; // level bank 2 at base 0x500
    localparam logic [15:0] L3 = 16'h0548; // level bank 3
    localparam int LIM[4] = '{2, 3, 4, 5}; // ticks for codes 11,10,01,00
    logic i_sys_clk, i_rst_n, i_post_done, o_io_hit, o_sys_reset, o_diag_indicator_zero, o_wdog_running, h, hi, lo;
    gdw_io_req_s i_io_req;
    logic [31:0] o_io_rdata, q;
    logic [31:0] cfg; // bridge config value, moved mid-run to relocate the io base
    int errors = 0;
    int checks_done = 0;
    int n;
    gdw_watchdog #(.TICK_CYC(4), .T100MS_TICKS(2), .T1S_TICKS(3), .T10S_TICKS(4), .T1MIN_TICKS(5))
        gdw_watchdog_inst (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_io_req(i_io_req),
        .i_gpio_base_cfg(cfg), .i_post_done(i_post_done), .o_io_rdata(o_io_rdata), .o_io_hit(o_io_hit),
        .o_sys_reset(o_sys_reset), .o_diag_indicator_zero(o_diag_indicator_zero), .o_wdog_running(o_wdog_running));
    gdw_host_model gdw_host_model_inst (.i_sys_clk(i_sys_clk), .i_io_rdata(o_io_rdata), .i_io_hit(o_io_hit),
        .o_io_req(i_io_req));
    // free-running clock
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task rd(input logic [15:0] a);
        gdw_host_model_inst.io(1'b0, a, 32'h0, q, h);
    endtask : rd
    task wr(input logic [15:0] a, input logic [31:0] d);
        gdw_host_model_inst.io(1'b1, a, d, q, h);
    endtask : wr
    // short reset pulse, clears a fired watchdog
    task rst;
        @(negedge i_sys_clk);
        i_rst_n = 1'b0;
        @(negedge i_sys_clk);
        i_rst_n = 1'b1;
    endtask : rst
    task close_out;
        $display("checks=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : close_out
    // hang guard, far beyond the expected run
    initial
    begin
        #200000;
        errors++;
        close_out();
    end
    initial
    begin
        i_rst_n = 1'b0;
        i_post_done = 1'b0;
        cfg = 32'h0000_0501;
        repeat (2) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        rd(L2);
        check(q, 32'h1);
        check(h, 1'b1);
        rd(L3);
        check(q, 32'h0);
        rd(16'h0038); // zero-base address must miss
        check(q, 32'h0);
        check(h, 1'b0);
        i_post_done = 1'b1;
        // every period code, timed from the enabling write
        for (int k = 0; k < 4; k++)
        begin
            hi = ~k[1];
            lo = ~k[0];
            wr(L2, {28'h0, hi, 1'b0, lo, 1'b0});
            n = 0;
            while (o_sys_reset !== 1'b1 && n < 400)
            begin
                @(negedge i_sys_clk);
                n++;
            end
            check(n inside {[(LIM[k] - 1) * 4 : (LIM[k] + 1) * 4 + 2]}, 1'b1);
            check(o_diag_indicator_zero, !lo);
            rst();
        end
        // regular service holds off the reset, then it lapses
        wr(L2, 32'h0000_000a);
        for (int i = 0; i < 10; i++)
            wr(L3, {8'h0, i[0], 23'h0});
        check(o_sys_reset, 1'b0);
        repeat (20) @(negedge i_sys_clk);
        check(o_sys_reset, 1'b1);
        rst();
        // enable then disable before the minute runs out
        wr(L2, 32'h0);
        repeat (3) @(negedge i_sys_clk);
        check(o_wdog_running, 1'b1);
        wr(L2, 32'h1);
        repeat (40) @(negedge i_sys_clk);
        check({o_wdog_running, o_sys_reset}, 2'b00);
        rd(L2);
        check(q, 32'h1);
        // relocate the io base; the old address must then miss
        cfg = 32'h0000_0601;
        rd(16'h0638);
        check(q, 32'h1);
        check(h, 1'b1);
        rd(L2);
        check(q, 32'h0);
        check(h, 1'b0);
        close_out();
    end
endmodule : tb_gdw_watchdog
